// [rtl/kapc_pkg.sv]
// Constants, field layout and types of the keep-alive packet control block
package kapc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register port
	localparam int          ADDR_W        = 4;
	localparam int          DATA_W        = 32;
	localparam logic [3:0]  REG_CTRL      = 4'h0;
	localparam logic [3:0]  REG_STATUS    = 4'h4;
	localparam logic [31:0] CTRL_RESET    = 32'h0;

	// Control register fields
	localparam int          CTRL_KA_EN    = 0;
	localparam int          CTRL_FIFO_MSK = 1;
	localparam int          CTRL_CFG_LSB  = 2;
	localparam int          CTRL_CFG_MSB  = 3;
	localparam logic [1:0]  CFG_MII       = 2'h1;
	localparam logic [1:0]  CFG_EXT_MII   = 2'h2;

	// Status register fields
	localparam int          STAT_SEC_LSB  = 0;
	localparam int          STAT_CNT_LSB  = 16;
	localparam int          STAT_BUSY     = 24;
	localparam int          STAT_PEND     = 25;

	////////////////////////////////////////////////////////////////////////////
	// Frame header fields
	localparam int          HDR_RND_DIS   = 28;
	localparam int          HDR_FINAL     = 24;
	localparam int          HDR_DISCARD   = 23;
	localparam int          HDR_PKTID_MSB = 9;
	localparam int          HDR_PKTID_LSB = 2;
	localparam int          HDR_BND_MSB   = 1;
	localparam int          HDR_BND_LSB   = 0;

	// Keep-alive control word fields
	localparam int          CTL_ALERT_MSB = 31;
	localparam int          CTL_ALERT_LSB = 29;
	localparam int          CTL_HOST_PWR  = 28;
	localparam int          CTL_TRIG_MSB  = 27;
	localparam int          CTL_TRIG_LSB  = 24;
	localparam int          CTL_INT_MSB   = 15;
	localparam int          CTL_INT_LSB   = 0;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int          SYS_CLK_HZ    = 20_000_000;
	localparam int          TICK_S        = 1;
	localparam int          TICK_CYCLES   = SYS_CLK_HZ * TICK_S;
	localparam int          SEC_W         = 16;
	localparam logic [7:0]  ALERT_IDLE    = 8'hff;

	// Scan engine states
	typedef enum logic [1:0] {
		KAPC_IDLE,
		KAPC_READ,
		KAPC_EVAL,
		KAPC_SEND
	} kapc_state_e;

	// Pin number from the encoded alert field; codes 2 and 3 are swapped
	function automatic logic [2:0] kapc_alert_pin(input logic [2:0] code);
		unique case (code)
			3'h3: kapc_alert_pin = 3'h2;
			3'h2: kapc_alert_pin = 3'h3;
			default: kapc_alert_pin = code;
		endcase
	endfunction : kapc_alert_pin

endpackage : kapc_pkg

// [rtl/kapc_timer_if.sv]
// Link between the scan engine and the hidden interval timer
`timescale 1ns/1ps
interface kapc_timer_if;
	logic        clear;   // Hold timer at zero
	logic        tick;    // One-cycle pulse each second
	logic [15:0] seconds; // Seconds elapsed, valid with tick

	modport timer (input clear, output tick, output seconds);
	modport user  (output clear, input tick, input seconds);
endinterface : kapc_timer_if

// [rtl/kapc_interval_timer.sv]
// Hidden interval timer: prescaler to one-second ticks and a seconds count
`timescale 1ns/1ps
module kapc_interval_timer #(
	parameter int TICK_CYCLES = kapc_pkg::TICK_CYCLES
) (
	input  wire logic  sys_clk,
	input  wire logic  nrst,
	kapc_timer_if.timer tif
);
	import kapc_pkg::*;

	localparam int PW = $clog2(TICK_CYCLES + 1);

	logic [PW-1:0]    presc_ff;
	logic [SEC_W-1:0] sec_ff;
	logic             tick_ff;
	wire              wrap;

	// End of one second
	assign wrap = (presc_ff == PW'(TICK_CYCLES - 1));

	////////////////////////////////////////////////////////////////////////////
	// Prescaler and seconds count, both held at zero while cleared
	always_ff @(posedge sys_clk) begin
		if (!nrst || tif.clear) begin
			presc_ff <= '0;
			sec_ff   <= '0;
			tick_ff  <= 1'b0;
		end else begin
			tick_ff  <= wrap;
			presc_ff <= wrap ? '0 : presc_ff + PW'(1);
			if (wrap) begin
				sec_ff <= sec_ff + SEC_W'(1);
			end
		end
	end

	assign tif.tick    = tick_ff;
	assign tif.seconds = sec_ff;

endmodule : kapc_interval_timer

// [rtl/kapc_control.sv]
// Keep-alive packet control: decides when each stored packet is sent
`timescale 1ns/1ps
module kapc_control #(
	parameter int MAX_PKTS    = 16,
	parameter int IDX_W       = 4,
	parameter int TICK_CYCLES = kapc_pkg::TICK_CYCLES
) (
	input  wire logic                        sys_clk,
	input  wire logic                        nrst,
	// Register port
	input  wire logic [kapc_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [kapc_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output      logic [kapc_pkg::DATA_W-1:0] reg_rdata,
	// Stored packet fetch, data one cycle after the request
	output      logic                        kap_rd_en,
	output      logic [IDX_W-1:0]            kap_rd_index,
	input  wire logic [31:0]                 kap_frame_header,
	input  wire logic [31:0]                 kap_control_word,
	// Send request towards the transmit path
	output      logic                        tx_valid,
	input  wire logic                        tx_ready,
	output      logic [IDX_W-1:0]            tx_index,
	output      logic                        tx_roundup_en,
	output      logic [1:0]                  tx_roundup_boundary,
	output      logic                        tx_discard_on_max_collision,
	// System events
	input  wire logic [7:0]                  alert_pin_n,
	input  wire logic [15:0]                 wake_trigger_flags,
	input  wire logic                        host_bus_reset_n,
	input  wire logic                        host_bus_powered,
	input  wire logic                        transmit_reset_cmd
);
	import kapc_pkg::*;

	kapc_timer_if tif ();

	kapc_state_e      state_ff;
	kapc_state_e      nxt_state;
	logic [31:0]      ctrl_ff;
	logic [31:0]      rdata_ff;
	logic [IDX_W-1:0] idx_ff;
	logic [7:0]       sent_cnt_ff;
	logic [7:0]       alert_prev_ff;
	logic [15:0]      trig_prev_ff;
	logic             host_rst_prev_ff;
	logic             tick_pend_ff;
	logic [SEC_W-1:0] tick_sec_ff;
	logic [15:0]      trig_pend_ff;
	logic [7:0]       alert_pend_ff;
	logic             snap_tick_ff;
	logic [SEC_W-1:0] snap_sec_ff;
	logic [15:0]      snap_trig_ff;
	logic [7:0]       snap_alert_ff;
	logic [IDX_W-1:0] tx_index_ff;
	logic             tx_rnd_en_ff;
	logic [1:0]       tx_bnd_ff;
	logic             tx_discard_ff;
	logic             tx_final_ff;

	////////////////////////////////////////////////////////////////////////////
	// Control fields and event edges
	wire              ka_en;
	wire              fifo_rst_mask;
	wire [1:0]        cfg_mode;
	wire              mii_mode;
	wire [7:0]        alert_fall;
	wire [15:0]       trig_rise;
	wire              host_rst_rise;
	wire              any_pend;
	wire              start_pass;

	assign ka_en         = ctrl_ff[CTRL_KA_EN];
	assign fifo_rst_mask = ctrl_ff[CTRL_FIFO_MSK];
	assign cfg_mode      = ctrl_ff[CTRL_CFG_MSB:CTRL_CFG_LSB];
	assign mii_mode      = (cfg_mode == CFG_MII) || (cfg_mode == CFG_EXT_MII);
	assign alert_fall    = alert_prev_ff & ~alert_pin_n;
	assign trig_rise     = wake_trigger_flags & ~trig_prev_ff;
	assign host_rst_rise = host_bus_reset_n & ~host_rst_prev_ff;
	assign any_pend      = tick_pend_ff || (|trig_pend_ff) || (|alert_pend_ff);
	assign start_pass    = (state_ff == KAPC_IDLE) && any_pend;

	// Timer clear sources
	assign tif.clear = host_rst_rise | alert_fall[0] | alert_fall[1] |
	                   (transmit_reset_cmd & ~fifo_rst_mask) | ~ka_en;

	kapc_interval_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.tif     (tif)
	);

	////////////////////////////////////////////////////////////////////////////
	// Field decode of the fetched packet words
	wire [2:0]        alert_code;
	wire [2:0]        alert_pin;
	wire              alert_pin_ok;
	wire              alert_hit;
	wire              host_pwr_only;
	wire [3:0]        trig_sel;
	wire              trig_hit;
	wire [15:0]       interval;
	wire [15:0]       low_zero;
	wire              timer_hit;
	wire              send_hit;
	wire              final_pkt;
	wire              last_slot;

	assign alert_code    = kap_control_word[CTL_ALERT_MSB:CTL_ALERT_LSB];
	assign alert_pin     = kapc_alert_pin(alert_code);
	assign alert_pin_ok  = (alert_pin < 3'h2) || !mii_mode;
	assign alert_hit     = (alert_code != 3'h0) && alert_pin_ok &&
	                       snap_alert_ff[alert_pin];
	assign host_pwr_only = kap_control_word[CTL_HOST_PWR];
	assign trig_sel      = kap_control_word[CTL_TRIG_MSB:CTL_TRIG_LSB];
	assign trig_hit      = (trig_sel != 4'h0) && snap_trig_ff[trig_sel];
	assign interval      = kap_control_word[CTL_INT_MSB:CTL_INT_LSB];

	// Bit k matches when the seconds count is a multiple of 2^k; bit 0 every second
	genvar k;
	generate
		for (k = 0; k < 16; k++) begin : g_low_zero
			if (k == 0) begin : g_first
				assign low_zero[k] = 1'b1;
			end else begin : g_rest
				assign low_zero[k] = ~|snap_sec_ff[k-1:0];
			end
		end
	endgenerate

	assign timer_hit = snap_tick_ff && (|(interval & low_zero)) &&
	                   (!host_pwr_only || host_bus_powered);
	// One decision per packet per pass, however many causes agree
	assign send_hit  = timer_hit || trig_hit || alert_hit;
	assign final_pkt = kap_frame_header[HDR_FINAL];
	assign last_slot = (idx_ff == IDX_W'(MAX_PKTS - 1));

	////////////////////////////////////////////////////////////////////////////
	// Scan engine next state
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			KAPC_IDLE: begin
				if (start_pass) begin
					nxt_state = KAPC_READ;
				end
			end
			KAPC_READ: nxt_state = KAPC_EVAL;
			KAPC_EVAL: begin
				if (send_hit) begin
					nxt_state = KAPC_SEND;
				end else if (final_pkt || last_slot) begin
					nxt_state = KAPC_IDLE;
				end else begin
					nxt_state = KAPC_READ;
				end
			end
			KAPC_SEND: begin
				if (tx_ready) begin
					nxt_state = (tx_final_ff || last_slot) ? KAPC_IDLE : KAPC_READ;
				end
			end
		endcase
	end

	// Scan engine state and packet index
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state_ff <= KAPC_IDLE;
			idx_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			if (start_pass) begin
				idx_ff <= '0;
			end else if (nxt_state == KAPC_READ && state_ff != KAPC_IDLE) begin
				idx_ff <= idx_ff + IDX_W'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Edge history of the event inputs
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			alert_prev_ff    <= ALERT_IDLE;
			trig_prev_ff     <= '0;
			host_rst_prev_ff <= 1'b1;
		end else begin
			alert_prev_ff    <= alert_pin_n;
			trig_prev_ff     <= wake_trigger_flags;
			host_rst_prev_ff <= host_bus_reset_n;
		end
	end

	// Pending events; new events win over the consume at pass start
	always_ff @(posedge sys_clk) begin
		if (!nrst || !ka_en) begin
			tick_pend_ff  <= 1'b0;
			tick_sec_ff   <= '0;
			trig_pend_ff  <= '0;
			alert_pend_ff <= '0;
		end else begin
			tick_pend_ff  <= (tick_pend_ff && !start_pass) || tif.tick;
			trig_pend_ff  <= (start_pass ? 16'h0 : trig_pend_ff) | trig_rise;
			alert_pend_ff <= (start_pass ? 8'h0 : alert_pend_ff) | alert_fall;
			if (tif.tick) begin
				tick_sec_ff <= tif.seconds;
			end
		end
	end

	// Snapshot of the causes evaluated by one pass
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			snap_tick_ff  <= 1'b0;
			snap_sec_ff   <= '0;
			snap_trig_ff  <= '0;
			snap_alert_ff <= '0;
		end else if (start_pass) begin
			snap_tick_ff  <= tick_pend_ff;
			snap_sec_ff   <= tick_sec_ff;
			snap_trig_ff  <= trig_pend_ff;
			snap_alert_ff <= alert_pend_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Send attributes; packet identifier bits are not used
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			tx_index_ff   <= '0;
			tx_rnd_en_ff  <= 1'b0;
			tx_bnd_ff     <= 2'h0;
			tx_discard_ff <= 1'b0;
			tx_final_ff   <= 1'b0;
		end else if (state_ff == KAPC_EVAL && send_hit) begin
			tx_final_ff   <= final_pkt;
			tx_index_ff   <= idx_ff;
			tx_rnd_en_ff  <= !kap_frame_header[HDR_RND_DIS];
			tx_bnd_ff     <= kap_frame_header[HDR_BND_MSB:HDR_BND_LSB];
			tx_discard_ff <= kap_frame_header[HDR_DISCARD];
		end
	end

	// Count of packets handed to the transmit path
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sent_cnt_ff <= '0;
		end else if (tx_valid && tx_ready) begin
			sent_cnt_ff <= sent_cnt_ff + 8'h01;
		end
	end

	assign kap_rd_en                   = (state_ff == KAPC_READ);
	assign kap_rd_index                = idx_ff;
	assign tx_valid                    = (state_ff == KAPC_SEND);
	assign tx_index                    = tx_index_ff;
	assign tx_roundup_en               = tx_rnd_en_ff;
	assign tx_roundup_boundary         = tx_bnd_ff;
	assign tx_discard_on_max_collision = tx_discard_ff;

	////////////////////////////////////////////////////////////////////////////
	// Register port decode
	wire        sel_ctrl;
	wire        sel_stat;
	wire [31:0] stat_word;
	wire [31:0] rd_mux;

	assign sel_ctrl  = (reg_addr == REG_CTRL);
	assign sel_stat  = (reg_addr == REG_STATUS);
	assign stat_word = {6'h0, any_pend, (state_ff != KAPC_IDLE), sent_cnt_ff, tif.seconds};
	assign rd_mux    = sel_ctrl ? {28'h0, ctrl_ff[3:0]} :
	                   sel_stat ? stat_word : 32'h0;

	// Control register write
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl_ff <= CTRL_RESET;
		end else if (reg_wr && sel_ctrl) begin
			ctrl_ff <= {28'h0, reg_wdata[3:0]};
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= reg_rd ? rd_mux : 32'h0;
		end
	end

	assign reg_rdata = rdata_ff;

endmodule : kapc_control

// [test/kapc_control_monitor.sv]
// Port checker of the keep-alive packet control block
`timescale 1ns/1ps
module kapc_control_monitor
	import kapc_pkg::*;
#(
	parameter int IDX_W = 4
) (
	input wire logic                        sys_clk,
	input wire logic                        nrst,
	input wire logic                        reg_rd,
	input wire logic [kapc_pkg::DATA_W-1:0] reg_rdata,
	input wire logic                        kap_rd_en,
	input wire logic [IDX_W-1:0]            kap_rd_index,
	input wire logic [31:0]                 kap_frame_header,
	input wire logic                        tx_valid,
	input wire logic                        tx_ready,
	input wire logic [IDX_W-1:0]            tx_index,
	input wire logic                        tx_roundup_en,
	input wire logic [1:0]                  tx_roundup_boundary,
	input wire logic                        tx_discard_on_max_collision
);
	logic             fetch_ff;
	logic [31:0]      hdr_ff;
	logic [IDX_W-1:0] idx_ff;

	////////////////////////////////////////////////////////////////////////////
	// Keep the header word and index of the packet being fetched
	always_ff @(posedge sys_clk) begin
		fetch_ff <= kap_rd_en;
		if (kap_rd_en) begin
			idx_ff <= kap_rd_index;
		end
		if (fetch_ff) begin
			hdr_ff <= kap_frame_header;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////////////////
	// Read data only after a read; fetch strobe, send timing, send attributes and send hold
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside the read answer cycle");
	fetch_pulse_a: assert property (kap_rd_en |=> !kap_rd_en)
		else $error("fetch strobe longer than one cycle");
	send_fetch_a: assert property ($rose(tx_valid) |-> $past(kap_rd_en, 2))
		else $error("send without a fetch two cycles before");
	send_index_a: assert property ($rose(tx_valid) |-> tx_index == idx_ff)
		else $error("send index differs from fetched index");
	roundup_en_a: assert property ($rose(tx_valid) |-> tx_roundup_en == !hdr_ff[28])
		else $error("roundup enable wrong");
	roundup_bound_a: assert property ($rose(tx_valid) |-> tx_roundup_boundary == hdr_ff[1:0])
		else $error("roundup boundary wrong");
	discard_flag_a: assert property ($rose(tx_valid) |-> tx_discard_on_max_collision == hdr_ff[23])
		else $error("discard flag wrong");
	send_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_index))
		else $error("send request dropped or changed");
	send_excl_a: assert property (tx_valid |-> !kap_rd_en)
		else $error("fetch while a send is pending");

endmodule : kapc_control_monitor

// [test/kapc_store.sv]
// Packet store and transmit acceptor beside the control block
`timescale 1ns/1ps
module kapc_store (
	input  wire logic        sys_clk,
	input  wire logic        kap_rd_en,
	input  wire logic [3:0]  kap_rd_index,
	output      logic [31:0] kap_frame_header,
	output      logic [31:0] kap_control_word,
	output      logic        tx_ready,
	input  wire logic        stall
);
	logic [31:0] hdr_mem [16];
	logic [31:0] ctl_mem [16];
	logic [1:0]  slow_ff;

	// Every packet final and inert until loaded
	initial begin
		slow_ff = 2'h0;
		tx_ready = 1'b0;
		kap_frame_header = 32'h0;
		kap_control_word = 32'h0;
		for (int i = 0; i < 16; i++) begin
			hdr_mem[i] = 32'h0100_0000;
			ctl_mem[i] = 32'h0;
		end
	end

	// Words valid one cycle after fetch, scrambled otherwise; ready slow when stalled
	always @(posedge sys_clk) begin
		if (kap_rd_en) begin
			kap_frame_header <= hdr_mem[kap_rd_index];
			kap_control_word <= ctl_mem[kap_rd_index];
		end else begin
			kap_frame_header <= ~kap_frame_header;
			kap_control_word <= ~kap_control_word;
		end
		slow_ff <= slow_ff + 2'h1;
		tx_ready <= !stall || (slow_ff == 2'h3);
	end
endmodule : kapc_store

// [test/testbench.sv]
// Self-checking bench of the keep-alive packet control block
`timescale 1ns/1ps
module testbench;
	import kapc_pkg::*;
	logic        sys_clk, nrst, reg_wr, reg_rd, kap_rd_en, tx_valid, tx_ready, stall;
	logic        tx_rnd_en, tx_discard, host_rst_n, host_pwr, reset_cmd;
	logic [3:0]  reg_addr, kap_rd_index, tx_index;
	logic [1:0]  tx_bound;
	logic [7:0]  alert_pin_n;
	logic [15:0] flags;
	logic [31:0] reg_wdata, reg_rdata, hdr, ctl, st, w;
	logic [7:0]  sent[$];
	int          num_errors, n_checks, seed, p;

	// Clock, 50 ns period
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	kapc_control #(.TICK_CYCLES(20)) kapc_control_inst (
		.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .kap_rd_en(kap_rd_en),
		.kap_rd_index(kap_rd_index), .kap_frame_header(hdr), .kap_control_word(ctl),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_index(tx_index),
		.tx_roundup_en(tx_rnd_en), .tx_roundup_boundary(tx_bound),
		.tx_discard_on_max_collision(tx_discard), .alert_pin_n(alert_pin_n),
		.wake_trigger_flags(flags), .host_bus_reset_n(host_rst_n),
		.host_bus_powered(host_pwr), .transmit_reset_cmd(reset_cmd));
	kapc_store kapc_store_inst (
		.sys_clk(sys_clk), .kap_rd_en(kap_rd_en), .kap_rd_index(kap_rd_index),
		.kap_frame_header(hdr), .kap_control_word(ctl), .tx_ready(tx_ready), .stall(stall));

	// Log of accepted sends
	always @(posedge sys_clk) begin
		if (nrst && tx_valid && tx_ready) begin
			sent.push_back({tx_index, tx_rnd_en, tx_bound, tx_discard});
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : idle

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge sys_clk) reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge sys_clk) reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	task automatic load(input logic [31:0] c);
		kapc_store_inst.hdr_mem[0] = $random(seed) | 32'h0100_0000;
		kapc_store_inst.ctl_mem[0] = c & 32'hff00_ffff;
	endtask : load

	task automatic fall(input int pin);
		@(posedge sys_clk) alert_pin_n <= ~(8'h1 << pin);
		idle(3);
		alert_pin_n <= 8'hff;
		idle(16);
	endtask : fall

	// Expected send attributes from the stored header
	function automatic logic [7:0] exp_tx(input int i);
		logic [31:0] h;
		h = kapc_store_inst.hdr_mem[i];
		return {i[3:0], !h[28], h[1:0], h[23]};
	endfunction : exp_tx

	task automatic expect_sends(input int n, input int idx, input int step);
		check(32'(sent.size()), 32'(n));
		for (int j = 0; sent.size() > 0; j++)
			check({24'h0, sent.pop_front()}, {24'h0, exp_tx(idx + j * step)});
	endtask : expect_sends

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	// Watchdog
	initial begin
		idle(20000);
		num_errors++;
		end_of_test();
	end

	initial begin
		seed = 32'h35a0;
		{nrst, reg_wr, reg_rd, reset_cmd, host_pwr, stall} = '0;
		{reg_addr, reg_wdata, flags} = '0;
		host_rst_n = 1'b1;
		alert_pin_n = 8'hff;
		idle(2);
		nrst <= 1'b1;
		rd(4'h0, st);
		check(st, 32'h0);
		rd(4'h4, st);
		check(st, 32'h0);
		w = $random(seed);
		wr(4'h0, w);
		rd(4'h0, st);
		check(st, {28'h0, w[3:0]});
		rd(4'h8, st);
		check(st, 32'h0);
		$display("registers done");
		// Alert pins under each interface mode
		for (int m = 0; m < 3; m++) begin
			wr(4'h0, {28'h0, m[1:0], 2'h1});
			for (int c = 0; c < 8; c++) begin
				p = (c == 2) ? 3 : (c == 3) ? 2 : c;
				load({c[2:0], 29'h0});
				fall(p);
				expect_sends((c > 0 && (m == 0 || p == 1)) ? 1 : 0, 0, 0);
			end
		end
		// Scan order, stop after final packet
		wr(4'h0, 32'h1);
		for (int i = 0; i < 3; i++) begin
			kapc_store_inst.hdr_mem[i] = {7'h0, i == 1, 24'h0};
			kapc_store_inst.ctl_mem[i] = 32'h2000_0000;
		end
		fall(1);
		expect_sends(2, 0, 1);
		$display("alert pins done");
		// Trigger flags, slow acceptor
		stall <= 1'b1;
		for (int s = 0; s < 16; s++) begin
			load({4'h0, s[3:0], 24'h0});
			@(posedge sys_clk) flags <= (s == 0) ? 16'hffff : (16'h1 << s);
			idle(16);
			flags <= 16'h0;
			expect_sends(s > 0 ? 1 : 0, 0, 0);
		end
		stall <= 1'b0;
		$display("trigger flags done");
		// Interval timer and host power
		for (int k = 0; k < 4; k++) begin
			wr(4'h0, 32'h0);
			load({3'h0, k < 2, 12'h0, (k == 3) ? 16'h0 : 16'h2});
			host_pwr <= k inside {1, 3};
			wr(4'h0, 32'h1);
			idle(170);
			expect_sends((k == 1 || k == 2) ? 4 : 0, 0, 0);
		end
		// Trigger and one-second timer hit in the same pass send once
		wr(4'h0, 32'h0);
		load({4'h0, 4'h1, 8'h0, 16'h1});
		wr(4'h0, 32'h1);
		idle(19);
		@(posedge sys_clk) flags <= 16'h2;
		idle(10);
		flags <= 16'h0;
		expect_sends(1, 0, 0);
		$display("interval timer done");
		// Timer clearing sources; the fourth is masked
		load(32'h0);
		for (int k = 0; k < 5; k++) begin
			wr(4'h0, (k == 3) ? 32'h3 : 32'h1);
			idle(50);
			@(posedge sys_clk) begin
				reset_cmd <= (k == 0 || k == 3);
				host_rst_n <= (k != 1);
				alert_pin_n[0] <= (k != 2);
			end
			@(posedge sys_clk) {reset_cmd, host_rst_n, alert_pin_n} <= {2'h1, 8'hff};
			if (k == 4) wr(4'h0, 32'h0);
			rd(4'h4, st);
			check({31'h0, st[15:0] == 16'h0}, {31'h0, k != 3});
		end
		$display("timer clearing done");
		end_of_test();
	end
endmodule : testbench

bind kapc_control kapc_control_monitor #(.IDX_W(IDX_W)) kapc_control_monitor_inst (
	.sys_clk(sys_clk), .nrst(nrst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.kap_rd_en(kap_rd_en), .kap_rd_index(kap_rd_index), .kap_frame_header(kap_frame_header),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_index(tx_index),
	.tx_roundup_en(tx_roundup_en), .tx_roundup_boundary(tx_roundup_boundary),
	.tx_discard_on_max_collision(tx_discard_on_max_collision));
